// ===== exec_unit.sv
// fetch, decode and execute of the arithmetic, compare, skip, branch and transfer instructions.
// assumes program memory, register file, i/o space and data space answer reads combinationally.
`timescale 1ns/1ps
module exec_unit
  import exec_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             srst,
  output logic      [PC_W-1:0]  prog_addr,
  input  wire logic [15:0]      prog_data,
  output logic      [4:0]       rf_raddr_a,
  input  wire logic [7:0]       rf_rdata_a,
  output logic      [4:0]       rf_raddr_b,
  input  wire logic [7:0]       rf_rdata_b,
  output logic                  rf_we,
  output logic      [4:0]       rf_waddr,
  output logic      [7:0]       rf_wdata,
  output logic      [5:0]       io_raddr,
  output logic                  io_re,
  input  wire logic [7:0]       io_rdata,
  output logic                  io_we,
  output logic      [5:0]       io_waddr,
  output logic      [7:0]       io_wdata,
  output logic      [15:0]      dmem_addr,
  output logic                  dmem_re,
  input  wire logic [7:0]       dmem_rdata,
  output logic                  dmem_we,
  output logic      [7:0]       dmem_wdata,
  output logic      [7:0]       flag_register
);

  typedef enum logic [1:0] {ST_RUN, ST_LD, ST_ST, ST_LPM} state_t;

  state_t             state;
  logic [PC_W-1:0]    pc;
  logic [1:0]         stall_cnt;
  logic               skip_q;
  logic [4:0]         mem_reg;
  logic [15:0]        zptr;
  logic [PC_W-1:0]    stack [STACK_DEPTH];

  logic [15:0]        ir;
  logic               exec_now;
  instr_class_t       cls;
  alu_op_t            op;
  logic               use_imm;
  logic               wr_rd;
  logic [7:0]         upd;
  logic [4:0]         dst;
  logic [7:0]         imm;
  logic [7:0]         opa;
  logic [7:0]         opb;
  logic [7:0]         alu_res;
  logic [7:0]         alu_flags;
  logic [15:0]        zval;

  // register write is one cycle late, so reads see it through this bypass
  function automatic logic [7:0] bypass(input logic [4:0] ad, input logic [7:0] raw,
                                        input logic we, input logic [4:0] wa,
                                        input logic [7:0] wd);
    bypass = (we && wa == ad) ? wd : raw;
  endfunction : bypass

  // relative target: pc plus sign-extended offset plus one
  function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] p,
                                                 input logic [11:0] k);
    rel_target = p + k[PC_W-1:0] + 9'h001;
  endfunction : rel_target

  assign ir       = prog_data;
  assign exec_now = (state == ST_RUN) && (stall_cnt == 2'h0) && !skip_q;

  always_comb begin
    cls     = CLS_NONE;
    op      = ALU_PASS;
    use_imm = 1'b0;
    wr_rd   = 1'b0;
    upd     = 8'h00;
    dst     = ir[8:4];
    imm     = {ir[11:8], ir[3:0]};
    casez (ir)
      16'b0000_11??_????_????: begin cls = CLS_ALU; op = ALU_ADD; wr_rd = 1'b1; upd = UPD_ARITH; end
      16'b0001_11??_????_????: begin cls = CLS_ALU; op = ALU_ADC; wr_rd = 1'b1; upd = UPD_ARITH; end
      16'b0001_10??_????_????: begin cls = CLS_ALU; op = ALU_SUB; wr_rd = 1'b1; upd = UPD_ARITH; end
      16'b0000_10??_????_????: begin cls = CLS_ALU; op = ALU_SBC; wr_rd = 1'b1; upd = UPD_ARITH; end
      16'b0000_01??_????_????: begin cls = CLS_CMP; op = ALU_SBC; upd = UPD_ARITH; end
      16'b0001_01??_????_????: begin cls = CLS_CMP; op = ALU_SUB; upd = UPD_ARITH; end
      16'b0001_00??_????_????: cls = CLS_EQSKIP;
      // and with itself is the self test: value rewritten unchanged
      16'b0010_00??_????_????: begin cls = CLS_ALU; op = ALU_AND; wr_rd = 1'b1; upd = UPD_LOGIC; end
      16'b0010_01??_????_????: begin cls = CLS_ALU; op = ALU_XOR; wr_rd = 1'b1; upd = UPD_LOGIC; end
      16'b0010_10??_????_????: begin cls = CLS_ALU; op = ALU_OR;  wr_rd = 1'b1; upd = UPD_LOGIC; end
      16'b0010_11??_????_????: begin cls = CLS_ALU; wr_rd = 1'b1; end
      16'b0011_????_????_????: begin
        cls = CLS_CMP; op = ALU_SUB; use_imm = 1'b1; upd = UPD_ARITH;
      end
      16'b0100_????_????_????: begin
        cls = CLS_ALU; op = ALU_SBC; use_imm = 1'b1; wr_rd = 1'b1; upd = UPD_ARITH;
      end
      16'b0101_????_????_????: begin
        cls = CLS_ALU; op = ALU_SUB; use_imm = 1'b1; wr_rd = 1'b1; upd = UPD_ARITH;
      end
      // selective set is merge_immediate with the mask
      16'b0110_????_????_????: begin
        cls = CLS_ALU; op = ALU_OR; use_imm = 1'b1; wr_rd = 1'b1; upd = UPD_LOGIC;
      end
      // selective clear arrives as mask_immediate with the complemented mask
      16'b0111_????_????_????: begin
        cls = CLS_ALU; op = ALU_AND; use_imm = 1'b1; wr_rd = 1'b1; upd = UPD_LOGIC;
      end
      // all ones fill is an immediate load of ff
      16'b1110_????_????_????: begin
        cls = CLS_ALU; use_imm = 1'b1; wr_rd = 1'b1;
      end
      16'b1001_010?_????0000: begin cls = CLS_ALU; op = ALU_COM; wr_rd = 1'b1; upd = UPD_INVERT; end
      16'b1001_010?_????0001: begin cls = CLS_ALU; op = ALU_NEG; wr_rd = 1'b1; upd = UPD_ARITH; end
      16'b1001_010?_????0011: begin cls = CLS_ALU; op = ALU_INC; wr_rd = 1'b1; upd = UPD_LOGIC; end
      16'b1001_010?_????1010: begin cls = CLS_ALU; op = ALU_DEC; wr_rd = 1'b1; upd = UPD_LOGIC; end
      16'b1000_000?_????0000: cls = CLS_LD;
      16'b1000_001?_????0000: cls = CLS_ST;
      16'b1001_1001_????_????, 16'b1001_1011_????_????: cls = CLS_IOSKIP;
      16'b1011_0???_????_????: cls = CLS_IN;
      16'b1011_1???_????_????: cls = CLS_OUT;
      16'b1100_????_????_????: cls = CLS_JUMP;
      16'b1101_????_????_????: cls = CLS_CALL;
      16'b1111_0???_????_????: cls = CLS_BRANCH;
      16'b1111_11??_????_0???: cls = CLS_REGSKIP;
      default:                 cls = CLS_NONE;
    endcase
    if (ir == OP_RET || ir == OP_INTERRUPT_EXIT) begin
      cls = CLS_RET;
    end
    if (ir == OP_LPM) begin
      cls = CLS_LPM;
    end
    if (use_imm) begin
      dst = {1'b1, ir[7:4]};
    end
  end

  // read ports: z pointer on memory instructions, stored register on the store's second cycle
  always_comb begin
    rf_raddr_a = dst;
    rf_raddr_b = {ir[9], ir[3:0]};
    if (state == ST_ST) begin
      rf_raddr_b = mem_reg;
    end else if (cls == CLS_LD || cls == CLS_ST || cls == CLS_LPM) begin
      rf_raddr_a = REG_ZLO;
      rf_raddr_b = REG_ZHI;
    end
  end

  assign opa  = bypass(rf_raddr_a, rf_rdata_a, rf_we, rf_waddr, rf_wdata);
  // the word on the bus during a store's second cycle is not executed, so its immediate is ignored
  assign opb  = (use_imm && state == ST_RUN) ? imm :
                bypass(rf_raddr_b, rf_rdata_b, rf_we, rf_waddr, rf_wdata);
  assign zval = {opb, opa};

  assign io_raddr  = (cls == CLS_IOSKIP) ? {1'b0, ir[7:3]} : {ir[10:9], ir[3:0]};
  assign io_re     = exec_now && (cls == CLS_IN || cls == CLS_IOSKIP);
  assign prog_addr = (state == ST_LPM) ? zptr[PC_W:1] : pc;

  exec_alu u_alu (
    .op     (op),
    .a      (opa),
    .b      (opb),
    .cin    (flag_register[FLAG_C]),
    .zin    (flag_register[FLAG_Z]),
    .result (alu_res),
    .flags  (alu_flags)
  );

  // sequencing: program counter, stall count, skip and memory states
  always_ff @(posedge mclk) begin
    if (srst) begin
      state     <= ST_RUN;
      pc        <= '0;
      stall_cnt <= 2'h0;
      skip_q    <= 1'b0;
      mem_reg   <= 5'h00;
      zptr      <= 16'h0000;
    end else begin
      skip_q <= 1'b0;
      case (state)
        ST_LD:  state <= ST_RUN;
        ST_ST:  state <= ST_RUN;
        ST_LPM: begin
          state     <= ST_RUN;
          stall_cnt <= STALL_BRANCH;
        end
        ST_RUN: begin
          if (stall_cnt != 2'h0) begin
            stall_cnt <= stall_cnt - 2'h1;
          end else if (skip_q) begin
            pc <= pc + 9'h001;
          end else begin
            pc <= pc + 9'h001;
            case (cls)
              CLS_EQSKIP:  skip_q <= (opa == opb);
              CLS_REGSKIP: skip_q <= (opa[ir[2:0]] == ir[9]);
              CLS_IOSKIP:  skip_q <= (io_rdata[ir[2:0]] == ir[9]);
              CLS_BRANCH: begin
                // bit 10 selects clear form; derived branches are aliases of this test
                if (flag_register[ir[2:0]] ^ ir[10]) begin
                  pc        <= rel_target(pc, {{5{ir[9]}}, ir[9:3]});
                  stall_cnt <= STALL_BRANCH;
                end
              end
              CLS_JUMP: begin
                pc        <= rel_target(pc, ir[11:0]);
                stall_cnt <= STALL_BRANCH;
              end
              CLS_CALL: begin
                pc        <= rel_target(pc, ir[11:0]);
                stall_cnt <= STALL_CALL;
              end
              CLS_RET: begin
                pc        <= stack[0];
                stall_cnt <= STALL_RET;
              end
              CLS_LD, CLS_ST: begin
                state   <= (cls == CLS_LD) ? ST_LD : ST_ST;
                mem_reg <= ir[8:4];
              end
              CLS_LPM: begin
                state <= ST_LPM;
                zptr  <= zval;
              end
              default: ;
            endcase
          end
        end
        default: state <= ST_RUN;
      endcase
    end
  end

  // hardware return stack; overflow silently drops the oldest entry
  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack[i] <= '0;
      end
    end else if (exec_now && cls == CLS_CALL) begin
      stack[0] <= pc + 9'h001;
      for (int i = 1; i < STACK_DEPTH; i++) begin
        stack[i] <= stack[i-1];
      end
    end else if (exec_now && cls == CLS_RET) begin
      for (int i = 0; i < STACK_DEPTH - 1; i++) begin
        stack[i] <= stack[i+1];
      end
    end
  end

  // flags: only the masked bits follow the alu
  always_ff @(posedge mclk) begin
    if (srst) begin
      flag_register <= FLAG_RESET;
    end else if (exec_now) begin
      flag_register <= (flag_register & ~upd) | (alu_flags & upd);
      if (ir == OP_INTERRUPT_EXIT) begin
        flag_register[FLAG_I] <= 1'b1;
      end
    end
  end

  // register write-back, one cycle after the execute cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      rf_we    <= 1'b0;
      rf_waddr <= 5'h00;
      rf_wdata <= 8'h00;
    end else begin
      rf_we <= 1'b0;
      if (state == ST_LD) begin
        rf_we    <= 1'b1;
        rf_waddr <= mem_reg;
        rf_wdata <= dmem_rdata;
      end else if (state == ST_LPM) begin
        rf_we    <= 1'b1;
        rf_waddr <= REG_ZERO;
        rf_wdata <= zptr[0] ? prog_data[15:8] : prog_data[7:0];
      end else if (exec_now && cls == CLS_IN) begin
        rf_we    <= 1'b1;
        rf_waddr <= ir[8:4];
        rf_wdata <= io_rdata;
      end else if (exec_now && wr_rd) begin
        rf_we    <= 1'b1;
        rf_waddr <= dst;
        rf_wdata <= (op == ALU_PASS) ? opb : alu_res;
      end
    end
  end

  // i/o writes
  always_ff @(posedge mclk) begin
    if (srst) begin
      io_we    <= 1'b0;
      io_waddr <= 6'h00;
      io_wdata <= 8'h00;
    end else begin
      io_we <= exec_now && cls == CLS_OUT;
      if (exec_now && cls == CLS_OUT) begin
        io_waddr <= {ir[10:9], ir[3:0]};
        io_wdata <= opa;
      end
    end
  end

  // data space: address on the first cycle, load data on the second, store write strobe on the third
  always_ff @(posedge mclk) begin
    if (srst) begin
      dmem_addr  <= 16'h0000;
      dmem_re    <= 1'b0;
      dmem_we    <= 1'b0;
      dmem_wdata <= 8'h00;
    end else begin
      dmem_re <= exec_now && cls == CLS_LD;
      dmem_we <= (state == ST_ST);
      if (exec_now && (cls == CLS_LD || cls == CLS_ST)) begin
        dmem_addr <= zval;
      end
      if (state == ST_ST) begin
        dmem_wdata <= opb;
      end
    end
  end

endmodule : exec_unit

// ===== exec_pkg.sv
// constants, opcode patterns and enumerations shared by the execute unit and its alu.
// assumes 16-bit instruction words and a 512-word program space.
package exec_pkg;

  localparam int PC_W = 9;

  // flag register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  localparam logic [7:0] FLAG_RESET   = 8'h00;
  localparam logic [7:0] UPD_ARITH    = 8'h3f;
  localparam logic [7:0] UPD_LOGIC    = 8'h1e;
  localparam logic [7:0] UPD_INVERT   = 8'h1f;
  localparam logic [7:0] ALL_ONES     = 8'hff;
  localparam logic [7:0] ZERO_BYTE    = 8'h00;

  // z pointer lives in the top two working registers, lpm target is register 0
  localparam logic [4:0] REG_ZLO      = 5'h1e;
  localparam logic [4:0] REG_ZHI      = 5'h1f;
  localparam logic [4:0] REG_ZERO     = 5'h00;

  // fixed opcodes
  localparam logic [15:0] OP_RET      = 16'h9508;
  localparam logic [15:0] OP_INTERRUPT_EXIT     = 16'h9518;
  localparam logic [15:0] OP_LPM      = 16'h95c8;

  // extra stall cycles after the first execute cycle
  localparam logic [1:0] STALL_BRANCH = 2'h1;
  localparam logic [1:0] STALL_CALL   = 2'h2;
  localparam logic [1:0] STALL_RET    = 2'h3;

  localparam int STACK_DEPTH = 3;

  typedef enum logic [3:0] {
    ALU_PASS, ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_AND, ALU_OR, ALU_XOR,
    ALU_COM, ALU_NEG, ALU_INC, ALU_DEC
  } alu_op_t;

  typedef enum logic [3:0] {
    CLS_NONE, CLS_ALU, CLS_CMP, CLS_EQSKIP, CLS_REGSKIP, CLS_IOSKIP, CLS_BRANCH,
    CLS_JUMP, CLS_CALL, CLS_RET, CLS_LD, CLS_ST, CLS_LPM, CLS_IN, CLS_OUT
  } instr_class_t;

endpackage : exec_pkg

// ===== exec_alu.sv
// eight-bit arithmetic and logic unit with flag generation.
// assumes the caller picks which flags it keeps; purely combinational.
`timescale 1ns/1ps
module exec_alu
  import exec_pkg::*;
(
  input  wire alu_op_t    op,
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       cin,
  input  wire logic       zin,
  output logic      [7:0] result,
  output logic      [7:0] flags
);

  logic [8:0] wide;
  logic [4:0] nib;
  logic [7:0] x;
  logic [7:0] y;
  logic       ci;
  logic       c;
  logic       v;
  logic       h;
  logic       z;

  always_comb begin
    wide   = 9'h000;
    nib    = 5'h00;
    x      = a;
    y      = b;
    ci     = 1'b0;
    c      = 1'b0;
    v      = 1'b0;
    h      = 1'b0;
    result = a;
    case (op)
      ALU_ADD, ALU_ADC: begin
        ci     = (op == ALU_ADC) ? cin : 1'b0;
        wide   = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        nib    = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        result = wide[7:0];
        c      = wide[8];
        h      = nib[4];
        v      = (a[7] & b[7] & ~result[7]) | (~a[7] & ~b[7] & result[7]);
      end
      ALU_SUB, ALU_SBC, ALU_NEG: begin
        // negate is zero minus the operand
        x      = (op == ALU_NEG) ? ZERO_BYTE : a;
        y      = (op == ALU_NEG) ? a : b;
        ci     = (op == ALU_SBC) ? cin : 1'b0;
        wide   = {1'b0, x} - {1'b0, y} - {8'h00, ci};
        nib    = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, ci};
        result = wide[7:0];
        c      = wide[8];
        h      = nib[4];
        v      = (x[7] & ~y[7] & ~result[7]) | (~x[7] & y[7] & result[7]);
      end
      ALU_AND:  result = a & b;
      ALU_OR:   result = a | b;
      ALU_XOR:  result = a ^ b;
      ALU_COM: begin
        result = ALL_ONES - a;
        c      = 1'b1;
      end
      ALU_INC: begin
        result = a + 8'h01;
        v      = (result == 8'h80);
      end
      ALU_DEC: begin
        result = a - 8'h01;
        v      = (result == 8'h7f);
      end
      default:  result = a;
    endcase
  end

  // carried subtraction keeps zero only if it was already zero
  assign z = (result == ZERO_BYTE) & ((op == ALU_SBC) ? zin : 1'b1);

  always_comb begin
    flags         = 8'h00;
    flags[FLAG_C] = c;
    flags[FLAG_Z] = z;
    flags[FLAG_N] = result[7];
    flags[FLAG_V] = v;
    flags[FLAG_S] = result[7] ^ v;
    flags[FLAG_H] = h;
  end

endmodule : exec_alu

// ===== exec_unit_monitor.sv
// concurrent checks on the execute unit's data-space, write-back and flag ports.
// assumes it is bound onto exec_unit; one clock domain, reset srst.
`timescale 1ns/1ps
module exec_unit_monitor
  import exec_pkg::*;
(
  input wire logic            mclk,
  input wire logic            srst,
  input wire logic [PC_W-1:0] prog_addr,
  input wire logic [7:0]      rf_rdata_b,
  input wire logic            rf_we,
  input wire logic [7:0]      rf_wdata,
  input wire logic            io_re,
  input wire logic            io_we,
  input wire logic            dmem_re,
  input wire logic [7:0]      dmem_rdata,
  input wire logic            dmem_we,
  input wire logic [7:0]      dmem_wdata,
  input wire logic [7:0]      flag_register
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence s_load_issue;
    dmem_re && !rf_we && !dmem_we;
  endsequence
  sequence s_load_land;
    rf_we && !dmem_re && rf_wdata == $past(dmem_rdata);
  endsequence

  a_load_issue: assert property (dmem_re |-> s_load_issue)
    else $error("load strobe overlaps another write");
  a_load_lands: assert property (s_load_issue |=> s_load_land)
    else $error("loaded byte not written back in the next cycle");
  a_load_pc_hold: assert property (dmem_re |=> $stable(prog_addr))
    else $error("program address moved during second load cycle");
  a_store_clean: assert property (dmem_we |-> !dmem_re && !rf_we && !$past(dmem_we))
    else $error("store strobe not a lone pulse");
  a_store_data: assert property (dmem_we |-> dmem_wdata == $past(rf_rdata_b))
    else $error("stored byte differs from source register");
  a_flags_held: assert property (dmem_re || dmem_we |-> $stable(flag_register))
    else $error("flags changed by a pointer transfer");
  a_sign_flag: assert property (flag_register[FLAG_S] ==
    (flag_register[FLAG_N] ^ flag_register[FLAG_V]))
    else $error("sign flag differs from negative xor overflow");
  a_reset_quiet: assert property ($fell(srst) |-> flag_register == FLAG_RESET
    && prog_addr == '0 && !rf_we && !dmem_we && !dmem_re && !io_we)
    else $error("outputs not at rest in first cycle after reset");
  a_io_read_quiet: assert property (io_re |=> $stable(flag_register))
    else $error("flags changed by an i/o read");
  c_load: cover property (s_load_issue ##1 s_load_land);
endmodule : exec_unit_monitor

bind exec_unit exec_unit_monitor mon (.mclk(mclk), .srst(srst), .prog_addr(prog_addr),
  .rf_rdata_b(rf_rdata_b), .rf_we(rf_we), .rf_wdata(rf_wdata), .io_re(io_re), .io_we(io_we),
  .dmem_re(dmem_re), .dmem_rdata(dmem_rdata), .dmem_we(dmem_we), .dmem_wdata(dmem_wdata),
  .flag_register(flag_register));

// ===== exec_env_model.sv
// program memory, register file, i/o space and data space around the execute unit.
// assumes the bench preloads the arrays only while reset is held.
`timescale 1ns/1ps
module exec_env_model
  import exec_pkg::*;
(
  input  wire logic            mclk,
  input  wire logic [PC_W-1:0] prog_addr,
  output logic      [15:0]     prog_data,
  input  wire logic [4:0]      rf_raddr_a,
  output logic      [7:0]      rf_rdata_a,
  input  wire logic [4:0]      rf_raddr_b,
  output logic      [7:0]      rf_rdata_b,
  input  wire logic            rf_we,
  input  wire logic [4:0]      rf_waddr,
  input  wire logic [7:0]      rf_wdata,
  input  wire logic [5:0]      io_raddr,
  output logic      [7:0]      io_rdata,
  input  wire logic            io_we,
  input  wire logic [5:0]      io_waddr,
  input  wire logic [7:0]      io_wdata,
  input  wire logic [15:0]     dmem_addr,
  output logic      [7:0]      dmem_rdata,
  input  wire logic            dmem_we,
  input  wire logic [7:0]      dmem_wdata
);
  logic [15:0] prog [512];
  logic [7:0]  rf   [32];
  logic [7:0]  io   [64];
  logic [7:0]  dm   [256];

  // data space folds onto 256 bytes; upper address bits ignored
  assign prog_data  = prog[prog_addr];
  assign rf_rdata_a = rf[rf_raddr_a];
  assign rf_rdata_b = rf[rf_raddr_b];
  assign io_rdata   = io[io_raddr];
  assign dmem_rdata = dm[dmem_addr[7:0]];

  always @(posedge mclk) begin
    if (rf_we) rf[rf_waddr] <= rf_wdata;
    if (io_we) io[io_waddr] <= io_wdata;
    if (dmem_we) dm[dmem_addr[7:0]] <= dmem_wdata;
  end
endmodule : exec_env_model

// ===== exec_unit_tb.sv
// self-checking bench: random alu, branch and skip programs plus a transfer program.
// assumes exec_env_model answers all reads combinationally.
`timescale 1ns/1ps
module exec_unit_tb
  import exec_pkg::*;
;
  logic            mclk = 1'b0;
  logic            srst = 1'b1;
  logic [PC_W-1:0] prog_addr;
  logic [15:0]     prog_data, dmem_addr;
  logic [4:0]      rf_raddr_a, rf_raddr_b, rf_waddr;
  logic [7:0]      rf_rdata_a, rf_rdata_b, rf_wdata, io_rdata, io_wdata, dmem_rdata;
  logic [7:0]      dmem_wdata, flag_register;
  logic [5:0]      io_raddr, io_waddr;
  logic            rf_we, io_re, io_we, dmem_re, dmem_we;
  int              bad_count = 0, num_checks = 0, seed = 80, ticks = 0;

  // entry order: add adc sub sbc and xor or copy cmp cmpc, then immediates, negate invert test load
  localparam logic [15:0] OP_WORD [20] = '{16'h0f01, 16'h1f01, 16'h1b01, 16'h0b01, 16'h2301,
    16'h2701, 16'h2b01, 16'h2f01, 16'h1701, 16'h0701, 16'h5000, 16'h4000, 16'h7000, 16'h6000,
    16'h3000, 16'h7000, 16'h9501, 16'h9500, 16'h2300, 16'he000};
  localparam logic [3:0]  OP_KIND [20] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h5, 4'h7,
    4'h2, 4'h3, 4'h2, 4'h3, 4'h4, 4'h5, 4'h2, 4'ha, 4'h8, 4'h9, 4'hb, 4'h7};
  localparam logic [19:0] OP_IMM   = 20'h8fc00;
  localparam logic [19:0] OP_STORE = 20'hfbcff;

  exec_unit dut (.mclk(mclk), .srst(srst), .prog_addr(prog_addr), .prog_data(prog_data),
    .rf_raddr_a(rf_raddr_a), .rf_rdata_a(rf_rdata_a), .rf_raddr_b(rf_raddr_b),
    .rf_rdata_b(rf_rdata_b), .rf_we(rf_we), .rf_waddr(rf_waddr), .rf_wdata(rf_wdata),
    .io_raddr(io_raddr), .io_re(io_re), .io_rdata(io_rdata), .io_we(io_we),
    .io_waddr(io_waddr), .io_wdata(io_wdata), .dmem_addr(dmem_addr), .dmem_re(dmem_re),
    .dmem_rdata(dmem_rdata), .dmem_we(dmem_we), .dmem_wdata(dmem_wdata),
    .flag_register(flag_register));
  exec_env_model env (.mclk(mclk), .prog_addr(prog_addr), .prog_data(prog_data),
    .rf_raddr_a(rf_raddr_a), .rf_rdata_a(rf_rdata_a), .rf_raddr_b(rf_raddr_b),
    .rf_rdata_b(rf_rdata_b), .rf_we(rf_we), .rf_waddr(rf_waddr), .rf_wdata(rf_wdata),
    .io_raddr(io_raddr), .io_rdata(io_rdata), .io_we(io_we), .io_waddr(io_waddr),
    .io_wdata(io_wdata), .dmem_addr(dmem_addr), .dmem_rdata(dmem_rdata),
    .dmem_we(dmem_we), .dmem_wdata(dmem_wdata));

  always #4 mclk = ~mclk;

  // expected {flags, result}; kinds 8 negate, 9 invert, a masked clear, b self test
  function automatic logic [15:0] ref_alu(input logic [3:0] k, input logic [7:0] a, b, f);
    logic [7:0] x, y, r, n;
    logic       c;
    x = (k == 4'h8) ? 8'h00 : a;
    y = (k == 4'h8 || k == 4'hb) ? a : (k == 4'ha) ? ~b : b;
    c = f[FLAG_C] & (k == 4'h1 || k == 4'h3);
    n = f;
    case (k)
      4'h0, 4'h1: r = x + y + c;
      4'h2, 4'h3, 4'h8: r = x - y - c;
      4'h5: r = x | y;
      4'h6: r = x ^ y;
      4'h7: r = y;
      4'h9: r = ~x;
      default: r = x & y;
    endcase
    if (k <= 4'h1) begin
      n[FLAG_C] = x[7] & y[7] | y[7] & ~r[7] | ~r[7] & x[7];
      n[FLAG_H] = x[3] & y[3] | y[3] & ~r[3] | ~r[3] & x[3];
      n[FLAG_V] = x[7] & y[7] & ~r[7] | ~x[7] & ~y[7] & r[7];
    end else if (k == 4'h2 || k == 4'h3 || k == 4'h8) begin
      n[FLAG_C] = ~x[7] & y[7] | y[7] & r[7] | r[7] & ~x[7];
      n[FLAG_H] = ~x[3] & y[3] | y[3] & r[3] | r[3] & ~x[3];
      n[FLAG_V] = x[7] & ~y[7] & ~r[7] | ~x[7] & y[7] & r[7];
    end else if (k != 4'h7) begin
      n[FLAG_V] = 1'b0;
      if (k == 4'h9) n[FLAG_C] = 1'b1;
    end
    if (k != 4'h7) begin
      // borrow forms keep a zero flag only if it was already set
      n[FLAG_Z] = (r == 8'h00) & (k != 4'h3 | f[FLAG_Z]);
      n[FLAG_N] = r[7];
      n[FLAG_S] = n[FLAG_N] ^ n[FLAG_V];
    end
    return {n, r};
  endfunction : ref_alu

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic load_env(input logic [15:0] w [13]);
    for (int j = 0; j < 512; j++) env.prog[j] = (j < 13) ? w[j] : 16'h0000;
    for (int j = 0; j < 32; j++) env.rf[j] = 8'h00;
  endtask : load_env

  // releases reset and notes the cycle in which register wreg is written
  task automatic run_prog(input logic [4:0] wreg, output int cyc);
    cyc = -1;
    @(posedge mclk);
    srst <= 1'b0;
    for (int n = 0; n < 60; n++) begin
      #1;
      if (cyc < 0 && rf_we === 1'b1 && rf_waddr === wreg) cyc = n;
      @(posedge mclk);
    end
  endtask : run_prog

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  always @(posedge mclk) begin
    ticks++;
    if (ticks == 5000) begin
      bad_count++;
      $display("FAIL %0t run exceeded its cycle budget", $time);
      print_verdict();
    end
  end

  initial begin
    logic [31:0] r1, r2;
    logic [15:0] w [13];
    logic [15:0] skw, pw;
    logic [7:0]  a, b, k, er, ef, f0, zl, old;
    logic [4:0]  i;
    logic [3:0]  s;
    logic [2:0]  sk, bt;
    logic        tk, sc;
    int          cyc;
    for (int it = 0; it < 40; it++) begin
      @(posedge mclk);
      srst <= 1'b1;
      @(posedge mclk);
      #1;
      r1 = $random(seed);
      r2 = $random(seed);
      i = 5'(it % 20);
      a = r1[7:0];
      b = (it % 4 == 3) ? a : r1[15:8];
      s = r1[20:17];
      sk = r1[23:21] % 3'd5;
      bt = r1[26:24];
      env.io[5] = r2[7:0];
      {f0, er} = ref_alu(4'h2, 8'h00, {7'h00, r1[16]}, FLAG_RESET);
      {ef, er} = ref_alu(OP_KIND[i], a, b, f0);
      if (!OP_STORE[i]) er = a;
      k = (OP_KIND[i] == 4'ha) ? ~b : b;
      tk = ef[s[2:0]] ^ s[3];
      case (sk)
        3'd0: begin skw = 16'h1301; sc = (er == b); end
        3'd1: begin skw = {13'h1fa0, bt}; sc = ~er[bt]; end
        3'd2: begin skw = {13'h1fe0, bt}; sc = er[bt]; end
        3'd3: begin skw = {13'h1325, bt}; sc = ~r2[bt]; end
        default: begin skw = {13'h1365, bt}; sc = r2[bt]; end
      endcase
      w = '{{4'he, a[7:4], 4'h0, a[3:0]}, {4'he, b[7:4], 4'h1, b[3:0]},
        {12'he03, 3'h0, r1[16]}, 16'h1b23,
        OP_IMM[i] ? (OP_WORD[i] | {4'h0, k[7:4], 4'h0, k[3:0]}) : OP_WORD[i],
        {5'h1e, s[3], 7'h02, s[2:0]}, 16'he555, 16'h0000, 16'hea6a, skw, 16'he171,
        16'he282, 16'h0000};
      load_env(w);
      run_prog(5'd24, cyc);
      check(env.rf[16], er, "alu result");
      check(flag_register, ef, "alu flags");
      check(env.rf[21], tk ? 8'h00 : 8'h55, "branch");
      check(env.rf[23], sc ? 8'h00 : 8'h11, "skip");
      check(8'(cyc), 8'(12 - tk), "branch timing");
    end
    $display("alu, branch and skip test done");
    @(posedge mclk);
    srst <= 1'b1;
    @(posedge mclk);
    #1;
    r1 = $random(seed);
    zl = r1[7:0];
    b = r1[15:8];
    for (int j = 0; j < 256; j++) env.dm[j] = r1[23:16] ^ j[7:0];
    old = env.dm[zl];
    w = '{16'hd007, 16'h8140, 16'h8310, 16'hb155, 16'h95c8, 16'hf00f, 16'he999, 16'hc005,
      {4'he, zl[7:4], 4'he, zl[3:0]}, 16'he0f0, {4'he, b[7:4], 4'h1, b[3:0]}, 16'hb915, 16'h9518};
    load_env(w);
    pw = env.prog[zl[7:1]];
    run_prog(5'd0, cyc);
    check(env.dm[zl], b, "pointer write");
    check(env.rf[20], old, "pointer read");
    check(env.io[5], b, "port write");
    check(env.rf[21], b, "port read");
    check(env.rf[0], zl[0] ? pw[15:8] : pw[7:0], "code byte");
    check(env.rf[25], 8'h00, "irq branch");
    check(flag_register, 8'h80, "exit flags");
    check(8'(cyc), 8'd18, "transfer timing");
    $display("transfer test done");
    print_verdict();
  end
endmodule : exec_unit_tb
